// *** verilog/etp_pkg.sv ***
package etp_pkg;
  // ---------------------------------------------------------------
  // register map (word offsets are byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNT  = 4'h0;
  localparam logic [3:0] ADDR_OPTION = 4'h4;
  localparam logic [3:0] ADDR_INTCTL = 4'h8;
  localparam logic [3:0] ADDR_CTRL   = 4'hC;

  // option register fields
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_ASSIGN    = 3;
  localparam int OPT_EDGE      = 4;
  localparam int OPT_SOURCE    = 5;
  // interrupt control fields
  localparam int INT_FLAG      = 2;
  localparam int INT_ENABLE    = 5;
  // control register fields
  localparam int CTRL_SLEEP    = 0;
  localparam int CTRL_WDT_CLR  = 1;

  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;

  // timing: one instruction cycle is four phase clocks
  localparam int CLK_MHZ        = 250;
  localparam int PHASES         = 4;
  localparam int WRITE_INHIBIT  = 2;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } etp_phase_type;

  typedef struct packed {
    logic [3:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } etp_wb_req_type;
endpackage

// *** verilog/etp_sync.sv ***
`timescale 1ns/1ns
// two flip-flop synchroniser for the external count pin
module etp_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);
  import etp_pkg::*;

  logic meta_reg;

  // -------------------------------------------------------------
  // synchroniser
  // -------------------------------------------------------------
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // etp_sync

// *** verilog/etp_timer.sv ***
`timescale 1ns/1ns
// How it works
// R01 - source bit clear: count every instruction cycle
// R02 - count write blocks increments two cycles
// R03 - source bit set: count external pin edges
// R04 - edge bit: clear rising, set falling
// R05 - prescaler serves counter or watchdog, not both
// R06 - prescaler count has no software access
// R07 - counter ratios span 1:2 to 1:256
// R08 - prescaler is eight bit, ratio programmable
// R09 - wrap FFh to 00h sets overflow flag
// R10 - enable bit clear masks overflow request
// R11 - software clears flag before re-enabling
// R12 - sleep stops the counter entirely
// R13 - no prescaler: pin feeds sampler directly
// R14 - sample prescaler output on Q2 and Q4
// R15 - pin high and low two oscillator periods
// R16 - prescaler divides pin before sampling
// R17 - prescaled pin period four periods over ratio
// R18 - count updates fixed clocks after edge; here one or two clocks after the synchronised edge, by phase
// R19 - count write clears prescaler when assigned
// R20 - assign bit and ratio field in option
// R21 - watchdog clear clears prescaler when assigned
// R22 - ratio n divides by two to n+1
module etp_timer #(
  parameter int PRESCALE_BITS = 8
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire etp_pkg::etp_wb_req_type wb_req,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic            external_count_input,
  output logic                 overflow_irq,
  output logic                 prescaler_tick_wdt
);
  import etp_pkg::*;

  // -------------------------------------------------------------
  // elaboration check
  // -------------------------------------------------------------
  if (PRESCALE_BITS != 8) begin : g_bad_width
    $error("prescaler width must be 8");
  end

  etp_phase_type      phase_reg;
  logic [7:0]         count_reg;
  logic [7:0]         option_reg;
  logic               flag_reg;
  logic               irq_en_reg;
  logic               sleep_reg;
  logic [1:0]         inhibit_reg;
  logic [PRESCALE_BITS-1:0] pre_reg;
  logic               pin_sync;
  logic               pin_last_reg;
  logic               samp_reg;
  logic               samp_last_reg;
  logic               inc_ext;
  logic               inc_int;
  logic               inc;
  logic               wb_hit;
  logic               wr_count;
  logic               wr_ctrl_clr;
  logic               pre_clr;
  logic               pin_edge;
  logic               pre_out;
  logic               pre_step;
  logic               cyc_end;
  logic               wrap;
  logic [7:0]         rd_next;

  // field decode used by several processes
  function automatic logic to_counter(input logic [7:0] opt);
    return ~opt[OPT_ASSIGN]; // R05
  endfunction

  // -------------------------------------------------------------
  // phase clocks
  // -------------------------------------------------------------
  // four phase clocks make one instruction cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= PH_Q1;
    end else begin
      unique case (phase_reg)
        PH_Q1: phase_reg <= PH_Q2;
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        PH_Q4: phase_reg <= PH_Q1;
      endcase
    end
  end

  assign cyc_end = (phase_reg == PH_Q4);

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  assign wb_hit      = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  assign wr_count    = wb_hit & wb_req.we & wb_req.sel[0] &
                       (wb_req.adr == ADDR_COUNT);
  assign wr_ctrl_clr = wb_hit & wb_req.we & wb_req.sel[0] &
                       (wb_req.adr == ADDR_CTRL) &
                       wb_req.dat[CTRL_WDT_CLR];

  // prescaler clear sources, by assignment
  assign pre_clr = (wr_count & to_counter(option_reg)) |      // R19
                   (wr_ctrl_clr & ~to_counter(option_reg));   // R21

  // -------------------------------------------------------------
  // edge detect on synchronised pin
  // -------------------------------------------------------------
  etp_sync u_sync (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .d     (external_count_input),
    .q     (pin_sync)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_last_reg <= 1'b0;
    end else begin
      pin_last_reg <= pin_sync;
    end
  end

  // selected edge of the count pin
  assign pin_edge = option_reg[OPT_EDGE] ?
                    (pin_last_reg & ~pin_sync) :       // R04
                    (~pin_last_reg & pin_sync);

  // prescaler input: pin edge in counter mode, else instruction cycle
  assign pre_step = option_reg[OPT_SOURCE] ? pin_edge : cyc_end;

  // -------------------------------------------------------------
  // prescaler
  // -------------------------------------------------------------
  // software can only clear pre_reg, never read or load it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= '0;
    end else if (pre_clr) begin
      pre_reg <= '0;                                 // R19 R21
    end else if (pre_step && !sleep_reg) begin
      pre_reg <= pre_reg + 1'b1;                     // R08 R06
    end
  end

  // ratio bit n toggles every 2^n steps, period 2^(n+1): symmetrical output
  // without prescaler the edge bit flips the pin so either edge rises
  assign pre_out = to_counter(option_reg) ?
      pre_reg[option_reg[OPT_RATIO_LSB +: 3]] :      // R07 R16 R22 R20
      (option_reg[OPT_SOURCE] &
       (pin_sync ^ option_reg[OPT_EDGE]));           // R13 R04

  // watchdog gets a tick when prescaler is its own
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescaler_tick_wdt <= 1'b0;
    end else begin
      prescaler_tick_wdt <= ~to_counter(option_reg) & pre_step
                            & ~sleep_reg;            // R05
    end
  end

  // -------------------------------------------------------------
  // Q2/Q4 sampler
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // idle-low pin seen through the reset edge select: no false rise
      samp_reg      <= OPTION_RST[OPT_EDGE];
      samp_last_reg <= OPTION_RST[OPT_EDGE];
    end else if ((phase_reg == PH_Q2 || phase_reg == PH_Q4)
                 && !sleep_reg) begin
      samp_reg      <= pre_out;                      // R14
      samp_last_reg <= samp_reg;
    end
  end

  // one increment per sampled rising of the prescaler output
  assign inc_ext = option_reg[OPT_SOURCE] & samp_reg & ~samp_last_reg
                   & (phase_reg == PH_Q3 || phase_reg == PH_Q1); // R18
  // internal source: with prescaler, its output rises once per ratio;
  // the Q2 sample is the first to see a step taken at Q4
  assign inc_int = ~option_reg[OPT_SOURCE] &
                   (to_counter(option_reg) ?
                    (samp_reg & ~samp_last_reg &
                     (phase_reg == PH_Q3 || phase_reg == PH_Q1)) :
                    cyc_end);                        // R01
  assign inc = (inc_ext | inc_int) & ~sleep_reg      // R12 R03
               & (inhibit_reg == 2'h0);              // R02

  // -------------------------------------------------------------
  // write inhibit
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      inhibit_reg <= 2'h0;
    end else if (wr_count) begin
      inhibit_reg <= 2'(WRITE_INHIBIT);              // R02
    end else if (cyc_end && inhibit_reg != 2'h0) begin
      inhibit_reg <= inhibit_reg - 2'h1;
    end
  end

  // -------------------------------------------------------------
  // count register
  // -------------------------------------------------------------
  assign wrap = inc & (count_reg == 8'hFF);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= COUNT_RST;
    end else if (wr_count) begin
      count_reg <= wb_req.dat[7:0];
    end else if (inc) begin
      count_reg <= count_reg + 8'h01;                // R01 R03
    end
  end

  // -------------------------------------------------------------
  // option, control and interrupt registers
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      option_reg <= OPTION_RST;
      sleep_reg  <= 1'b0;
    end else if (wb_hit && wb_req.we && wb_req.sel[0]) begin
      if (wb_req.adr == ADDR_OPTION) begin
        option_reg <= wb_req.dat[7:0];               // R20
      end
      if (wb_req.adr == ADDR_CTRL) begin
        sleep_reg <= wb_req.dat[CTRL_SLEEP];         // R12
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg   <= INTCTL_RST[INT_FLAG];
      irq_en_reg <= INTCTL_RST[INT_ENABLE];
    end else begin
      if (wb_hit && wb_req.we && wb_req.sel[0]
          && wb_req.adr == ADDR_INTCTL) begin
        irq_en_reg <= wb_req.dat[INT_ENABLE];
        flag_reg   <= wb_req.dat[INT_FLAG] | wrap;   // R11
      end else if (wrap) begin
        flag_reg <= 1'b1;                            // R09
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= flag_reg & irq_en_reg;         // R10
    end
  end

  // -------------------------------------------------------------
  // bus answer: one wait-free ack, dropped the next cycle
  // -------------------------------------------------------------
  always_comb begin
    rd_next = 8'h00;
    unique case (wb_req.adr)
      ADDR_COUNT:  rd_next = count_reg;
      ADDR_OPTION: rd_next = option_reg;
      ADDR_INTCTL: begin
        rd_next[INT_FLAG]   = flag_reg;
        rd_next[INT_ENABLE] = irq_en_reg;
      end
      ADDR_CTRL:   rd_next[CTRL_SLEEP] = sleep_reg;
      default:     rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? {24'h00_0000, rd_next} : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // a count write as seen on the bus
  sequence s_count_write;
    wr_count;
  endsequence

  // a step taken in plain timer mode, no prescaler
  sequence s_plain_step;
    inc && !option_reg[OPT_SOURCE] && !to_counter(option_reg);
  endsequence

  // a rising pin in counter mode with no prescaler, counting allowed
  sequence s_pin_rise_plain;
    $rose(pin_sync) && option_reg[OPT_SOURCE] && !option_reg[OPT_EDGE]
    && !to_counter(option_reg) && !sleep_reg && inhibit_reg == 2'h0;
  endsequence

  // the synchronised step follows within two clocks
  sequence s_step_soon;
    ##[1:2] inc;
  endsequence

  a_write_inhibit: assert property (s_count_write |=> !inc [*5]) // R02
    else $error("increment inside inhibit");

  a_wrap_sets_flag: assert property (wrap |=> flag_reg) // R09
    else $error("overflow flag not set");

  a_irq_masked: assert property (!irq_en_reg |=> !overflow_irq) // R10
    else $error("irq not masked");

  a_sleep_stop: assert property ( // R12
    sleep_reg && !wr_count |=> $stable(count_reg))
    else $error("count in sleep");

  // a mode change may bring a prescaled step into the same cycle
  a_timer_rate: assert property ( // R01
    s_plain_step |=> (!inc || option_reg[OPT_SOURCE]
                      || to_counter(option_reg)) [*3])
    else $error("timer faster than cycle");

  a_pre_clear: assert property ( // R19
    wr_count && to_counter(option_reg) |=> pre_reg == '0)
    else $error("prescaler kept");

  a_wdt_clear: assert property ( // R21
    wr_ctrl_clr && !to_counter(option_reg) |=> pre_reg == '0)
    else $error("wdt clear missed");

  a_bus_ack: assert property (wb_ack_o |=> !wb_ack_o) // ack drops after one cycle
    else $error("ack held");

  a_wdt_tick_only: assert property ( // R05
    to_counter(option_reg) |=> !prescaler_tick_wdt)
    else $error("watchdog tick while prescaler counts");

  a_flag_sticky: assert property ( // R11
    flag_reg && !(wb_hit && wb_req.we) |=> flag_reg)
    else $error("overflow flag lost without a write");

  a_sample_phase: assert property ( // R14
    !(phase_reg == PH_Q2 || phase_reg == PH_Q4) |=> $stable(samp_reg))
    else $error("sampler moved outside Q2 and Q4");

  a_pin_latency: assert property (s_pin_rise_plain |-> s_step_soon) // R18
    else $error("pin edge not counted in time");
endmodule // etp_timer

// *** bench/etp_pin_src.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// external count source driving the count pin
// ------------------------------------------------------------
module etp_pin_src #(
  parameter int HALF = 8
) (
  input  wire logic ref_clk,
  input  wire logic run,
  output logic      pin,
  output int        rises,
  output int        falls
);
  int t;

  // idle low, nothing counted yet
  initial begin
    pin = 1'b0;
    rises = 0;
    falls = 0;
    t = 0;
  end

  // toggle each HALF clocks; a high phase is always finished
  always @(posedge ref_clk) begin
    t <= (t == HALF - 1) ? 0 : t + 1;
    if (t == HALF - 1 && (run || pin)) begin
      pin <= !pin;
      if (pin) falls <= falls + 1;
      else rises <= rises + 1;
    end
  end
endmodule // etp_pin_src

// *** bench/test_eight_bit_timer_with_prescaler.sv ***
`timescale 1ns/1ns
module test_eight_bit_timer_with_prescaler;
  import etp_pkg::*;
  typedef struct packed {
    logic [3:0] adr;
    logic       we;
    logic [7:0] dat;
    logic [7:0] exp;
  } etp_row_type;

  logic           ref_clk = 1'b0;
  logic           rst_b = 1'b0;
  etp_wb_req_type wb_req = '0;
  logic [31:0]    wb_dat_o;
  logic           wb_ack_o;
  logic           pin;
  logic           overflow_irq;
  logic           tick;
  logic           run = 1'b0;
  logic [31:0]    rd;
  logic [7:0]     a;
  int             rises, falls, k0, x;
  int             tick_n = 0;
  int             errors = 0;
  int             checks = 0;
  etp_row_type    rows [10] = '{
    '{ADDR_COUNT, 1'b0, 8'h00, 8'h00}, '{ADDR_OPTION, 1'b0, 8'h00, 8'hFF},
    '{ADDR_INTCTL, 1'b0, 8'h00, 8'h00}, '{ADDR_CTRL, 1'b0, 8'h00, 8'h00},
    '{4'h2, 1'b1, 8'hAA, 8'h00}, '{4'h2, 1'b0, 8'h00, 8'h00},
    '{ADDR_CTRL, 1'b1, 8'h02, 8'h00}, '{ADDR_CTRL, 1'b0, 8'h00, 8'h00},
    '{ADDR_OPTION, 1'b1, 8'h08, 8'h00}, '{ADDR_OPTION, 1'b0, 8'h00, 8'h08}};

  // ------------------------------------------------------------
  // clock, counters, design and far side
  // ------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tick_n <= tick_n + int'(tick === 1'b1);

  etp_timer #(.PRESCALE_BITS(8)) uut (
    .ref_clk              (ref_clk),
    .rst_b                (rst_b),
    .wb_req               (wb_req),
    .wb_dat_o             (wb_dat_o),
    .wb_ack_o             (wb_ack_o),
    .external_count_input (pin),
    .overflow_irq         (overflow_irq),
    .prescaler_tick_wdt   (tick)
  );

  etp_pin_src #(.HALF(8)) src (
    .ref_clk (ref_clk),
    .run     (run),
    .pin     (pin),
    .rises   (rises),
    .falls   (falls)
  );

  // ------------------------------------------------------------
  // bus cycle, compares, verdict
  // ------------------------------------------------------------
  task automatic bus(input logic [3:0] adr, input logic we,
                     input logic [7:0] dat);
    @(posedge ref_clk);
    wb_req <= '{adr, {24'h0, dat}, 4'hF, we, 1'b1, 1'b1};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard, about five times the expected run length
  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].adr, rows[i].we, rows[i].dat);
      if (!rows[i].we) check_val(rd, {24'h0, rows[i].exp});
    end
    // timer mode: one step each instruction cycle
    bus(ADDR_COUNT, 1'b0, 8'h00);
    a = rd[7:0];
    repeat (37) @(posedge ref_clk);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    check_val(rd, {24'h0, a + 8'd10});
    // count write holds off two steps
    bus(ADDR_COUNT, 1'b1, 8'h10);
    repeat (30) @(posedge ref_clk);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    check_val(rd, 32'h16);
    // wrap sets the flag, masked request stays low
    bus(ADDR_COUNT, 1'b1, 8'hFE);
    repeat (30) @(posedge ref_clk);
    check_bit(overflow_irq, 1'b0);
    bus(ADDR_INTCTL, 1'b0, 8'h00);
    check_val(rd, 32'h04);
    check_bit(tick_n != 0, 1'b1);
    bus(ADDR_INTCTL, 1'b1, 8'h00);
    bus(ADDR_INTCTL, 1'b1, 8'h20);
    bus(ADDR_COUNT, 1'b1, 8'hFE);
    repeat (30) @(posedge ref_clk);
    check_bit(overflow_irq, 1'b1);
    bus(ADDR_INTCTL, 1'b0, 8'h00);
    check_val(rd, 32'h24);
    bus(ADDR_INTCTL, 1'b1, 8'h20);
    repeat (3) @(posedge ref_clk);
    check_bit(overflow_irq, 1'b0);
    // sleep freezes the count
    bus(ADDR_CTRL, 1'b1, 8'h01);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    a = rd[7:0];
    repeat (40) @(posedge ref_clk);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    check_val(rd, {24'h0, a});
    bus(ADDR_CTRL, 1'b1, 8'h00);
    // every ratio on the instruction clock, two steps per window
    for (int n = 0; n < 8; n++) begin
      bus(ADDR_OPTION, 1'b1, 8'(n));
      repeat (20) @(posedge ref_clk);
      // last ticks of the watchdog assignment have landed by now
      if (n == 0) k0 = tick_n;
      bus(ADDR_COUNT, 1'b0, 8'h00);
      a = rd[7:0];
      repeat ((16 << n) - 3) @(posedge ref_clk);
      bus(ADDR_COUNT, 1'b0, 8'h00);
      check_val(rd, {24'h0, a + 8'd2});
    end
    check_val(tick_n - k0, 32'h0);
    // pin edges: rising, falling, then divided by two
    for (int m = 0; m < 3; m++) begin
      bus(ADDR_OPTION, 1'b1, (m == 0) ? 8'h28 : (m == 1) ? 8'h38 : 8'h20);
      bus(ADDR_COUNT, 1'b1, 8'h00);
      repeat (10) @(posedge ref_clk);
      x = (m == 1) ? falls + 4 : rises + ((m == 0) ? 5 : 6);
      run <= 1'b1;
      while (((m == 1) ? falls : rises) < x) @(posedge ref_clk);
      run <= 1'b0;
      repeat (40) @(posedge ref_clk);
      bus(ADDR_COUNT, 1'b0, 8'h00);
      check_val(rd, (m == 0) ? 32'h5 : (m == 1) ? 32'h4 : 32'h3);
    end
    // second reset in mid-run
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(ADDR_OPTION, 1'b0, 8'h00);
    check_val(rd, 32'hFF);
    bus(ADDR_COUNT, 1'b0, 8'h00);
    check_val(rd, 32'h00);
    print_verdict();
  end
endmodule // test_eight_bit_timer_with_prescaler
